// file: dcf_cfg.svh
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH
`define DCF_WIDTH 18
`define DCF_DEPTH_SMALL 8192
`define DCF_DEPTH_LARGE 16384
`define DCF_AW 15
`define DCF_OFS_SERIAL 15'h03ff
`define DCF_OFS_PARALLEL 15'h007f
`define DCF_FT_LATENCY 3
`define DCF_SKID_DEPTH 8
`endif

// file: dcf_pkg.sv
package dcf_pkg;
    typedef enum logic [1:0] {
        DCF_IDLE = 2'b00,
        DCF_WAIT = 2'b01,
        DCF_SHOW = 2'b11
    } dcf_ft_state_t;
endpackage

// file: dcf_skid.sv
`timescale 1ns/1ps
module dcf_skid #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [AW:0] diff;
    assign diff = wp - rp;
    assign in_ready = diff != (AW+1)'(DEPTH);
    assign out_valid = wp != rp;
    assign out_data = mem[rp[AW-1:0]];
    always_ff @(posedge clock) begin
        if (in_valid && in_ready) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp <= wp + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp <= rp + 1'b1;
            end
        end
    end
endmodule // dcf_skid

// file: dcf_fifo.sv
`timescale 1ns/1ps
`include "dcf_cfg.svh"
// Functional notes
// - Mode pin low at reset: standard
// - Mode pin high at reset: fall-through
// - Fall-through first word after three edges
// - Output-ready and input-ready show status
// - Write captured when enabled, not full
// - Empty flag rises after first write
// - Almost-empty rises at offset plus one
// - Half-full falls above half depth
// - Almost-full falls at depth minus offset
// - Full at depth, writes ignored
// - Reads from full release flags
// - Almost-empty falls at empty offset
// - Last read empties, reads then ignored
// - Empty and full double registered
// - Load pin high: offsets 1023
// - Load pin low: offsets 127
module dcf_fifo #(
    parameter int DEPTH = `DCF_DEPTH_SMALL
) (
    // System
    input wire logic clock,
    input wire logic reset,
    // Straps
    input wire logic mode_select_serial_in,
    input wire logic offset_load_n,
    // Write side
    input wire logic write_clock,
    input wire logic write_enable_n,
    input wire logic [`DCF_WIDTH-1:0] data_in,
    // Read side
    input wire logic read_clock,
    input wire logic read_enable_n,
    output logic [`DCF_WIDTH-1:0] data_out,
    // Flags
    output logic fall_through_mode,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic input_ready_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic half_full_flag_n
);
    localparam int AW = `DCF_AW;
    localparam int IW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_W = (AW+1)'(DEPTH / 2);

    // ------------------------------------------------------------
    // Pin synchronisers and clock edges
    // ------------------------------------------------------------
    logic [2:0] wclk_s;
    logic [2:0] rclk_s;
    logic [1:0] wen_s;
    logic [1:0] ren_s;
    logic [1:0] mode_s;
    logic [1:0] load_s;
    logic [`DCF_WIDTH-1:0] din_s1;
    logic [`DCF_WIDTH-1:0] din_s2;
    always_ff @(posedge clock) begin
        wclk_s <= {wclk_s[1:0], write_clock};
        rclk_s <= {rclk_s[1:0], read_clock};
        wen_s <= {wen_s[0], write_enable_n};
        ren_s <= {ren_s[0], read_enable_n};
        mode_s <= {mode_s[0], mode_select_serial_in};
        load_s <= {load_s[0], offset_load_n};
        din_s1 <= data_in;
        din_s2 <= din_s1;
    end
    logic wedge;
    logic redge;
    assign wedge = wclk_s[1] && !wclk_s[2];
    assign redge = rclk_s[1] && !rclk_s[2];

    // ------------------------------------------------------------
    // Reset straps
    // ------------------------------------------------------------
    logic [AW:0] empty_ofs;
    logic [AW:0] full_ofs;
    always_ff @(posedge clock) begin
        if (reset) begin
            fall_through_mode <= mode_s[1];
            empty_ofs <= load_s[1] ? {1'b0, `DCF_OFS_SERIAL} : {1'b0, `DCF_OFS_PARALLEL};
            full_ofs <= load_s[1] ? {1'b0, `DCF_OFS_SERIAL} : {1'b0, `DCF_OFS_PARALLEL};
        end
    end

    function automatic logic [AW:0] occupancy(input logic [AW:0] a, input logic [AW:0] b);
        occupancy = a - b;
    endfunction

    // ------------------------------------------------------------
    // Write path into skid buffer
    // ------------------------------------------------------------
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] wcount;
    logic [AW:0] rcount;
    logic wr_full;
    logic wr_go;
    logic skid_in_ready;
    logic skid_valid;
    logic [`DCF_WIDTH-1:0] skid_data;
    logic skid_take;
    assign wcount = occupancy(wptr, rptr);
    assign wr_full = wcount == DEPTH_W;
    assign wr_go = wedge && !wen_s[1] && !wr_full && skid_in_ready;

    dcf_skid #(.WIDTH(`DCF_WIDTH), .DEPTH(`DCF_SKID_DEPTH)) u_skid (
        .clock(clock),
        .reset(reset),
        .in_valid(wr_go),
        .in_ready(skid_in_ready),
        .in_data(din_s2),
        .out_valid(skid_valid),
        .out_ready(skid_take),
        .out_data(skid_data)
    );

    logic [`DCF_WIDTH-1:0] mem [DEPTH];
    assign skid_take = skid_valid;
    always_ff @(posedge clock) begin
        if (skid_take) begin
            mem[wptr[IW-1:0]] <= skid_data;
        end
    end

    // ------------------------------------------------------------
    // Pointers and read path
    // ------------------------------------------------------------
    assign rcount = occupancy(wptr, rptr);
    logic rd_go;
    dcf_pkg::dcf_ft_state_t ft_state;
    logic [1:0] ft_cnt;
    logic ft_shown;
    always_comb begin
        if (fall_through_mode) begin
            rd_go = ft_state == dcf_pkg::DCF_SHOW && redge && !ren_s[1]
                && rcount != '0;
        end else begin
            rd_go = redge && !ren_s[1] && rcount != '0;
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            wptr <= '0;
        end else begin
            if (skid_take) begin
                wptr <= wptr + 1'b1;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            rptr <= '0;
            data_out <= '0;
        end else if (rd_go || (ft_state == dcf_pkg::DCF_WAIT && redge
                && ft_cnt == 2'(`DCF_FT_LATENCY - 1))) begin
            data_out <= mem[rptr[IW-1:0]];
            rptr <= rptr + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Fall-through presentation
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            ft_state <= dcf_pkg::DCF_IDLE;
            ft_cnt <= '0;
        end else if (fall_through_mode) begin
            case (ft_state)
                dcf_pkg::DCF_IDLE: begin
                    if (rcount != '0) begin
                        ft_state <= dcf_pkg::DCF_WAIT;
                        ft_cnt <= '0;
                    end
                end
                dcf_pkg::DCF_WAIT: begin
                    if (redge) begin
                        if (ft_cnt == 2'(`DCF_FT_LATENCY - 1)) begin
                            ft_state <= dcf_pkg::DCF_SHOW;
                        end else begin
                            ft_cnt <= ft_cnt + 1'b1;
                        end
                    end
                end
                dcf_pkg::DCF_SHOW: begin
                    if (redge && !ren_s[1] && rcount == '0) begin
                        ft_state <= dcf_pkg::DCF_IDLE;
                    end
                end
                default: ft_state <= dcf_pkg::DCF_IDLE;
            endcase
        end
    end
    assign ft_shown = ft_state == dcf_pkg::DCF_SHOW;

    // ------------------------------------------------------------
    // Flags on their own clock edges
    // ------------------------------------------------------------
    logic [1:0] ef_pipe;
    logic [1:0] ff_pipe;
    logic [AW:0] held;
    assign held = fall_through_mode ? rcount + {{AW{1'b0}}, ft_shown} : rcount;
    always_ff @(posedge clock) begin
        if (reset) begin
            ef_pipe <= '0;
            almost_empty_flag_n <= 1'b0;
        end else if (redge) begin
            ef_pipe <= {ef_pipe[0], fall_through_mode ? ft_shown : rcount != '0};
            almost_empty_flag_n <= rcount > empty_ofs;
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            ff_pipe <= '0;
            almost_full_flag_n <= 1'b1;
            half_full_flag_n <= 1'b1;
        end else if (wedge) begin
            ff_pipe <= {ff_pipe[0], wr_full};
            almost_full_flag_n <= !(wcount >= DEPTH_W - full_ofs);
            half_full_flag_n <= !(held > HALF_W);
        end
    end
    // Pipes hold "has data" and "full"; pins invert per mode
    assign empty_flag_n = fall_through_mode ? !ef_pipe[1] : ef_pipe[1];
    assign full_flag_n = fall_through_mode ? 1'b1 : !ff_pipe[1];
    assign input_ready_n = fall_through_mode ? ff_pipe[1] : 1'b1;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_no_overfill: assert property (@(posedge clock) disable iff (reset)
        wcount <= DEPTH_W) else $error("count above depth");
    a_full_blocks: assert property (@(posedge clock) disable iff (reset)
        wr_full |-> !wr_go) else $error("write taken while full");
    a_empty_read: assert property (@(posedge clock) disable iff (reset)
        rcount == '0 |-> !rd_go) else $error("read taken while empty");
    a_ptr_step: assert property (@(posedge clock) disable iff (reset)
        rd_go |=> rptr == $past(rptr) + 1'b1) else $error("read pointer stuck");
    a_ae_level: assert property (@(posedge clock) disable iff (reset)
        redge ##1 1'b1 |-> almost_empty_flag_n == ($past(rcount) > empty_ofs))
        else $error("almost empty wrong");
    a_ft_show: assert property (@(posedge clock) disable iff (reset)
        ft_state == dcf_pkg::DCF_SHOW |-> fall_through_mode)
        else $error("show outside fall-through");
    a_ft_latency: assert property (@(posedge clock) disable iff (reset)
        ft_state == dcf_pkg::DCF_WAIT && redge && ft_cnt == 2'(`DCF_FT_LATENCY - 1)
        |=> ft_shown)
        else $error("first word not shown");
    a_ef_stage: assert property (@(posedge clock) disable iff (reset)
        redge |=> ef_pipe[0] == $past(fall_through_mode ? ft_shown : rcount != '0))
        else $error("empty stage wrong");
    a_ff_stage: assert property (@(posedge clock) disable iff (reset)
        wedge |=> ff_pipe[0] == $past(wr_full))
        else $error("full stage wrong");
endmodule // dcf_fifo

// file: dcf_link_model.sv
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_link_model (
    // System clock
    input wire logic clock,
    // Writer
    output logic write_clock,
    output logic write_enable_n,
    output logic [`DCF_WIDTH-1:0] data_in,
    // Reader
    output logic read_clock,
    output logic read_enable_n
);
    initial begin
        write_clock = 1'b0;
        write_enable_n = 1'b1;
        data_in = '0;
        read_clock = 1'b0;
        read_enable_n = 1'b1;
    end
    // ----------------------------------------
    // One 84 ns link period per call
    // ----------------------------------------
    task automatic wr(input logic [`DCF_WIDTH-1:0] d, input logic en);
        @(posedge clock);
        write_enable_n <= ~en;
        data_in <= d;
        repeat (10) @(posedge clock);
        write_clock <= 1'b1;
        repeat (10) @(posedge clock);
        write_clock <= 1'b0;
        write_enable_n <= 1'b1;
        data_in <= ~d;
    endtask
    task automatic rd(input logic en);
        @(posedge clock);
        read_enable_n <= ~en;
        repeat (10) @(posedge clock);
        read_clock <= 1'b1;
        repeat (10) @(posedge clock);
        read_clock <= 1'b0;
        read_enable_n <= 1'b1;
    endtask
endmodule // dcf_link_model

// file: dcf_fifo_tb.sv
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_fifo_tb;
    localparam int DEPTH = 512;
    logic clock, reset, mode_select_serial_in, offset_load_n;
    logic write_clock, write_enable_n, read_clock, read_enable_n;
    logic [`DCF_WIDTH-1:0] data_in, data_out;
    logic fall_through_mode, empty_flag_n, full_flag_n, input_ready_n;
    logic almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
    int bad_count = 0;
    int n_checks = 0;
    int cnt;
    int fills[10] = '{1, 127, 128, 256, 257, 384, 385, 511, 512, 513};
    int drains[9] = '{511, 385, 384, 257, 256, 128, 127, 1, 0};

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        reset = 1'b1;
        mode_select_serial_in = 1'b0;
        offset_load_n = 1'b0;
    end

    dcf_link_model link (.clock, .write_clock, .write_enable_n, .data_in,
        .read_clock, .read_enable_n);
    dcf_fifo #(.DEPTH(DEPTH)) DUT (.clock, .reset, .mode_select_serial_in,
        .offset_load_n, .write_clock, .write_enable_n, .data_in, .read_clock,
        .read_enable_n, .data_out, .fall_through_mode, .empty_flag_n, .full_flag_n,
        .input_ready_n, .almost_empty_flag_n, .almost_full_flag_n, .half_full_flag_n);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [`DCF_WIDTH-1:0] pat(input int k);
        return `DCF_WIDTH'(k) ^ 18'h2a5a5;
    endfunction
    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t flag %s wrong", $time, what);
        end
    endtask
    task automatic chk_word(input logic [`DCF_WIDTH-1:0] got, input logic [`DCF_WIDTH-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flags(input int c);
        chk_bit(empty_flag_n, c != 0, "empty");
        chk_bit(almost_empty_flag_n, c >= 128, "almost empty");
        chk_bit(half_full_flag_n, c < 257, "half");
        chk_bit(almost_full_flag_n, c < 385, "almost full");
        chk_bit(full_flag_n, c < DEPTH, "full");
    endtask
    task automatic settle();
        repeat (3) begin
            link.rd(1'b0);
            link.wr('0, 1'b0);
        end
    endtask
    task automatic do_reset(input logic ft, input logic ld);
        @(posedge clock);
        reset <= 1'b1;
        mode_select_serial_in <= ft;
        offset_load_n <= ld;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #400000;
        bad_count++;
        $display("[ERR] %0t run took too long", $time);
        stop_test();
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        do_reset(1'b0, 1'b0);
        chk_bit(fall_through_mode, 1'b0, "mode");
        chk_flags(0);
        cnt = 0;
        foreach (fills[k]) begin
            while (cnt < fills[k]) begin
                link.wr(pat(cnt), 1'b1);
                cnt++;
            end
            settle();
            chk_flags(cnt > DEPTH ? DEPTH : cnt);
        end
        $display("Fill test done");
        cnt = 0;
        foreach (drains[k]) begin
            while (DEPTH - cnt > drains[k]) begin
                link.rd(1'b1);
                chk_word(data_out, pat(cnt));
                cnt++;
            end
            settle();
            chk_flags(drains[k]);
        end
        link.rd(1'b1);
        settle();
        chk_word(data_out, pat(DEPTH - 1));
        chk_flags(0);
        $display("Drain test done");
        do_reset(1'b1, 1'b1);
        chk_bit(fall_through_mode, 1'b1, "mode");
        chk_bit(empty_flag_n, 1'b1, "ready");
        chk_bit(input_ready_n, 1'b0, "space");
        link.wr(pat(7), 1'b1);
        link.wr(pat(8), 1'b1);
        repeat (3) link.rd(1'b0);
        chk_word(data_out, pat(7));
        repeat (2) link.rd(1'b0);
        chk_bit(empty_flag_n, 1'b0, "ready");
        link.rd(1'b1);
        repeat (2) link.rd(1'b0);
        chk_word(data_out, pat(8));
        link.rd(1'b1);
        settle();
        chk_bit(empty_flag_n, 1'b1, "ready");
        $display("Fall-through test done");
        stop_test();
    end
endmodule // dcf_fifo_tb
